//--- cpu_decoder_consts.vh
// Constants for the instruction decoder
`ifndef CPU_DECODER_CONSTS_VH
`define CPU_DECODER_CONSTS_VH
`define OPC_SHARED       8'hA5
`define SFR_SPACE_BIT    7
`define TRAP_SEL_BIT     0
`define CLASS_OTHER      5'h00
`define CLASS_CODE_WR    5'h01
`define CLASS_SW_BREAK   5'h02
`define CLASS_EXT_MOVE   5'h03
`define CLASS_CODE_DATA_POINTER  5'h04
`define CLASS_CODE_PC    5'h05
`define CLASS_MOV_DD     5'h06
`define CLASS_NIB_XCH    5'h07
`define CLASS_PUSH_POP   5'h08
`define CLASS_ROT_CARRY  5'h09
`define CLASS_SUB_BORROW 5'h0A
`define CLASS_XOR_DIRIMM 5'h0B
`define CLASS_OR_NBIT    5'h0C
`define CLASS_SHORT_JUMP 5'h0D
`define CLASS_LOAD_DATA_POINTER  5'h0E
`define CLASS_MOV_DIND   5'h0F
`define CLASS_ABS11      5'h10
`endif

//--- cpu_instruction_decoder.v
// Instruction decoder: opcode map, lengths, cycles, operand addressing
// Operation
// RL1: Immediate is one byte; pointer immediate two bytes
// RL2: Indirect uses register zero or one address
// RL3: Absolute target keeps upper five PC bits
// RL4: Direct low half RAM, high half special
// RL5: Relative operand is signed, added to PC
// RL6: Low nibble 8-F selects banked register
// RL7: Shared opcode chosen by pointer select setting
// RL8: Software break is one byte, one cycle
// RL9: External moves one byte, two cycles
// RL10: Code read at A plus pointer
// RL11: Code read at A plus PC
// RL12: Direct to direct move: three bytes, two
// RL13: Nibble exchange one byte, one cycle
// RL14: Push and pop two bytes, two cycles
// RL15: Rotates through carry update carry, one cycle
// RL16: Subtract with borrow updates three flags
// RL17: Xor immediate into direct: three, two
// RL18: Or inverted bit changes only carry
// RL19: Short jump relative, two bytes two cycles
// RL20: Pointer load: three bytes, two cycles
// RL21: Map by nibbles with lengths and cycles
// RL22: Indirect to direct move: two, two
// RL23: Cycles are machine cycles; all decode
`timescale 1ns/1ns
`include "cpu_decoder_consts.vh"
module cpu_instruction_decoder
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Instruction bytes from program memory
  input  wire        instr_valid,
  input  wire [7:0]  opcode,
  input  wire [7:0]  operand1,
  input  wire [7:0]  operand2,
  // Core state
  input  wire [15:0] pc_next,
  input  wire [7:0]  acc,
  input  wire        carry_in,
  input  wire [15:0] data_pointer,
  input  wire [7:0]  pointer_select_reg,
  input  wire [7:0]  reg0_value,
  input  wire [7:0]  reg1_value,
  input  wire [1:0]  bank_select,
  // Decode results
  output reg         dec_valid,
  output reg  [4:0]  instr_class,
  output reg  [1:0]  instr_bytes,
  output reg  [2:0]  instr_cycles,
  output reg  [7:0]  imm8,
  output reg  [15:0] imm16,
  output reg  [7:0]  indirect_addr,
  output reg  [4:0]  bank_reg_addr,
  output reg         bank_reg_used,
  output reg  [7:0]  direct_addr,
  output reg         direct_is_sfr,
  output reg  [15:0] jump_target,
  output reg  [15:0] code_addr,
  output reg  [15:0] ext_addr,
  output reg         debug_break,
  output reg  [7:0]  rot_result,
  output reg         rot_carry
);

  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];

  // Indirect pointer for the external moves uses bit 0 of the opcode
  wire [7:0] indirect_addr_w = opcode[0] ? reg1_value : reg0_value;

  reg [1:0]  next_bytes;
  reg [2:0]  next_cycles;
  reg [4:0]  next_class;
  reg [15:0] next_target;

  // Opcode map lookup: row by high nibble, column by low nibble
  always @*
  begin
    next_class  = `CLASS_OTHER;
    next_bytes  = 2'h1;
    next_cycles = 3'h1;
    next_target = pc_next;
    if (lo[3])
    begin
      // Banked register column, shared by every row [RL21]
      case (hi)
        4'h7, 4'hD:       next_bytes = 2'h2;
        4'h8, 4'hA:
        begin
          next_bytes  = 2'h2;
          next_cycles = 3'h2;
        end
        4'hB:
        begin
          next_bytes  = 2'h3;
          next_cycles = 3'h2;
        end
        default:          next_bytes = 2'h1;
      endcase
      if (hi == 4'hD) next_cycles = 3'h2;
      if (hi == 4'h9) next_class = `CLASS_SUB_BORROW;
    end
    else
    begin
      case (lo)
        4'h0:
        begin
          case (hi)
            4'h0: next_bytes = 2'h1;
            4'h1, 4'h2, 4'h3:
            begin
              next_bytes  = 2'h3;
              next_cycles = 3'h2;
            end
            4'h4, 4'h5, 4'h6, 4'h7:
            begin
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
            end
            4'h8:
            begin
              next_class  = `CLASS_SHORT_JUMP; // [RL19]
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
              next_target = pc_next + {{8{operand1[7]}}, operand1}; // [RL5]
            end
            4'h9:
            begin
              next_class  = `CLASS_LOAD_DATA_POINTER; // [RL20]
              next_bytes  = 2'h3;
              next_cycles = 3'h2;
            end
            4'hA, 4'hB:
            begin
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
            end
            4'hC, 4'hD:
            begin
              next_class  = `CLASS_PUSH_POP; // [RL14]
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
            end
            default:
            begin
              next_class  = `CLASS_EXT_MOVE; // [RL9]
              next_cycles = 3'h2;
            end
          endcase
          if (hi == 4'hA) next_class = `CLASS_OR_NBIT; // [RL18]
        end
        4'h1:
        begin
          next_class  = `CLASS_ABS11;
          next_bytes  = 2'h2;
          next_cycles = 3'h2;
          // Target stays in the current 2KB block [RL3]
          next_target = {pc_next[15:11], opcode[7:5], operand1};
        end
        4'h2:
        begin
          case (hi)
            4'h0, 4'h1:
            begin
              next_bytes  = 2'h3;
              next_cycles = 3'h2;
            end
            4'h2, 4'h3: next_cycles = 3'h2;
            4'h4, 4'h5, 4'h6, 4'hB, 4'hC, 4'hD, 4'hA: next_bytes = 2'h2;
            4'hE, 4'hF:
            begin
              next_class  = `CLASS_EXT_MOVE; // [RL9]
              next_cycles = 3'h2;
            end
            default:
            begin
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
            end
          endcase
        end
        4'h3:
        begin
          case (hi)
            4'h1, 4'h3: next_class = `CLASS_ROT_CARRY; // [RL15]
            4'h4, 4'h5, 4'h6:
            begin
              next_bytes  = 2'h3;
              next_cycles = 3'h2;
              if (hi == 4'h6) next_class = `CLASS_XOR_DIRIMM; // [RL17]
            end
            4'h7, 4'hA: next_cycles = 3'h2;
            4'h8:
            begin
              next_class  = `CLASS_CODE_PC; // [RL11]
              next_cycles = 3'h2;
            end
            4'h9:
            begin
              next_class  = `CLASS_CODE_DATA_POINTER; // [RL10]
              next_cycles = 3'h2;
            end
            4'hE, 4'hF:
            begin
              next_class  = `CLASS_EXT_MOVE; // [RL9]
              next_cycles = 3'h2;
            end
            default: next_cycles = 3'h1;
          endcase
        end
        4'h4:
        begin
          if (hi >= 4'h2 && hi <= 4'h7) next_bytes = 2'h2; // [RL1]
          if (hi == 4'h9)
          begin
            next_bytes = 2'h2;
            next_class = `CLASS_SUB_BORROW; // [RL16]
          end
          if (hi == 4'h8 || hi == 4'hA) next_cycles = 3'h4;
          if (hi == 4'hB)
          begin
            next_bytes  = 2'h3;
            next_cycles = 3'h2;
          end
        end
        4'h5:
        begin
          next_bytes = 2'h2;
          if (hi == 4'h7 || hi == 4'h8)
          begin
            next_bytes  = 2'h3; // [RL12]
            next_cycles = 3'h2;
            if (hi == 4'h8) next_class = `CLASS_MOV_DD;
          end
          if (hi == 4'hB || hi == 4'hD)
          begin
            next_bytes  = 2'h3;
            next_cycles = 3'h2;
          end
          if (hi == 4'h9) next_class = `CLASS_SUB_BORROW;
          if (hi == 4'hA)
          begin
            next_bytes  = 2'h1;
            // Shared opcode: pointer select picks the break [RL7] [RL8]
            if (pointer_select_reg[`TRAP_SEL_BIT])
            begin
              next_class  = `CLASS_SW_BREAK;
              next_cycles = 3'h1;
            end
            else
            begin
              next_class  = `CLASS_CODE_WR;
              next_cycles = 3'h2;
            end
          end
        end
        default:
        begin
          // Columns 6 and 7: indirect forms
          case (hi)
            4'h7: next_bytes = 2'h2;
            4'h8:
            begin
              next_class  = `CLASS_MOV_DIND; // [RL22]
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
            end
            4'hA:
            begin
              next_bytes  = 2'h2;
              next_cycles = 3'h2;
            end
            4'hB:
            begin
              next_bytes  = 2'h3;
              next_cycles = 3'h2;
            end
            4'hD: next_class = `CLASS_NIB_XCH; // [RL13]
            4'h9: next_class = `CLASS_SUB_BORROW;
            default: next_bytes = 2'h1;
          endcase
        end
      endcase
    end
  end

  // Registered decode; every map position is a real instruction [RL23]
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec_valid     <= 1'b0;
      instr_class   <= 5'h00;
      instr_bytes   <= 2'h0;
      instr_cycles  <= 3'h0;
      imm8          <= 8'h00;
      imm16         <= 16'h0000;
      indirect_addr <= 8'h00;
      bank_reg_addr <= 5'h00;
      bank_reg_used <= 1'b0;
      direct_addr   <= 8'h00;
      direct_is_sfr <= 1'b0;
      jump_target   <= 16'h0000;
      code_addr     <= 16'h0000;
      ext_addr      <= 16'h0000;
      debug_break   <= 1'b0;
      rot_result    <= 8'h00;
      rot_carry     <= 1'b0;
    end
    else
    begin
      dec_valid     <= instr_valid;
      instr_class   <= next_class;
      instr_bytes   <= next_bytes;
      instr_cycles  <= next_cycles;
      imm8          <= operand1; // [RL1]
      imm16         <= {operand1, operand2}; // [RL1]
      indirect_addr <= opcode[0] ? reg1_value : reg0_value; // [RL2]
      bank_reg_addr <= {bank_select, opcode[2:0]}; // [RL6]
      bank_reg_used <= lo[3];
      direct_addr   <= operand1;
      direct_is_sfr <= operand1[`SFR_SPACE_BIT]; // [RL4]
      jump_target   <= next_target;
      code_addr     <= (hi == 4'h8) ? pc_next + {8'h00, acc} // [RL11]
                       : data_pointer + {8'h00, acc}; // [RL10]
      // 16-bit pointer or 8-bit indirect, both to external memory [RL9]
      ext_addr      <= lo[1] ? {8'h00, indirect_addr_w} : data_pointer;
      debug_break   <= instr_valid && (next_class == `CLASS_SW_BREAK);
      // Rotate through carry; carry is the only flag touched [RL15]
      rot_result    <= (hi == 4'h3) ? {acc[6:0], carry_in}
                       : {carry_in, acc[7:1]};
      rot_carry     <= (hi == 4'h3) ? acc[7] : acc[0];
    end
  end

endmodule

//--- decoder_props.sv
// Assertion checker watching the instruction decoder ports
`timescale 1ns/1ns
`include "cpu_decoder_consts.vh"
module decoder_props
(
  // Clock and reset
  input wire        clock,
  input wire        rst_n,
  // Decode inputs
  input wire        instr_valid,
  input wire        carry_in,
  input wire [7:0]  opcode,
  input wire [7:0]  operand1,
  input wire [7:0]  operand2,
  input wire [7:0]  acc,
  input wire [7:0]  pointer_select_reg,
  input wire [7:0]  reg0_value,
  input wire [7:0]  reg1_value,
  input wire [15:0] pc_next,
  input wire [15:0] data_pointer,
  input wire [1:0]  bank_select,
  // Decode results
  input wire        dec_valid,
  input wire        debug_break,
  input wire        direct_is_sfr,
  input wire        bank_reg_used,
  input wire        rot_carry,
  input wire [4:0]  instr_class,
  input wire [4:0]  bank_reg_addr,
  input wire [1:0]  instr_bytes,
  input wire [2:0]  instr_cycles,
  input wire [7:0]  imm8,
  input wire [15:0] imm16,
  input wire [7:0]  direct_addr,
  input wire [7:0]  indirect_addr,
  input wire [7:0]  rot_result,
  input wire [15:0] jump_target,
  input wire [15:0] code_addr,
  input wire [15:0] ext_addr
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_valid_follows: assert property (
    instr_valid |=> dec_valid) else $error("no decode after valid input");
  a_break_select: assert property (
    instr_valid && opcode == 8'hA5 && pointer_select_reg[0] |=>
    debug_break && instr_bytes == 2'h1 && instr_cycles == 3'h1)
    else $error("software break decode wrong");
  a_code_write: assert property (
    instr_valid && opcode == 8'hA5 && !pointer_select_reg[0] |=>
    !debug_break && instr_class == `CLASS_CODE_WR)
    else $error("code write decode wrong");
  a_bank_reg: assert property (
    instr_valid && opcode[3] |=> bank_reg_used &&
    bank_reg_addr == {$past(bank_select), $past(opcode[2:0])})
    else $error("banked register select wrong");
  a_direct_space: assert property (
    instr_valid && opcode == 8'h85 |=> direct_is_sfr == $past(operand1[7]))
    else $error("direct space select wrong");
  a_indirect_sel: assert property (
    instr_valid && opcode[3:1] == 3'h3 |=> indirect_addr ==
    ($past(opcode[0]) ? $past(reg1_value) : $past(reg0_value)))
    else $error("indirect address wrong");
  a_rel_target: assert property (
    instr_valid && opcode == 8'h80 |=> jump_target ==
    $past(pc_next) + {{8{$past(operand1[7])}}, $past(operand1)})
    else $error("relative target wrong");
  a_abs_target: assert property (
    instr_valid && opcode[3:0] == 4'h1 |=> jump_target ==
    {$past(pc_next[15:11]), $past(opcode[7:5]), $past(operand1)})
    else $error("absolute target wrong");
  a_code_addr: assert property (
    instr_valid && opcode == 8'h93 |=>
    code_addr == $past(data_pointer) + $past(acc))
    else $error("code read address wrong");
  a_rotate_left: assert property (
    instr_valid && opcode == 8'h33 |=>
    {rot_carry, rot_result} == {$past(acc), $past(carry_in)})
    else $error("rotate through carry wrong");
  a_rotate_right: assert property (
    instr_valid && opcode == 8'h13 |=>
    {rot_result, rot_carry} == {$past(carry_in), $past(acc)})
    else $error("rotate right through carry wrong");
  a_valid_drop: assert property (
    !instr_valid |=> !dec_valid) else $error("decode without valid input");
  a_break_only: assert property (
    debug_break |-> $past(instr_valid) && $past(opcode) == 8'hA5 &&
    $past(pointer_select_reg[0]))
    else $error("software break without its opcode");
  a_imm_pair: assert property (
    instr_valid |=> imm8 == $past(operand1) &&
    imm16 == {$past(operand1), $past(operand2)})
    else $error("immediate operand wrong");
  a_direct_addr: assert property (
    instr_valid |=> direct_addr == $past(operand1))
    else $error("direct address wrong");
  a_code_pc: assert property (
    instr_valid && opcode == 8'h83 |=>
    code_addr == $past(pc_next) + $past(acc))
    else $error("pc relative code address wrong");
  a_ext_ptr: assert property (
    instr_valid && opcode == 8'hE0 |=> ext_addr == $past(data_pointer))
    else $error("pointer external address wrong");
  a_ext_ind: assert property (
    instr_valid && opcode == 8'hF3 |=> ext_addr == {8'h00, $past(reg1_value)})
    else $error("indirect external address wrong");
endmodule

bind cpu_instruction_decoder decoder_props u_props
(
  .clock              (clock),
  .rst_n              (rst_n),
  .instr_valid        (instr_valid),
  .carry_in           (carry_in),
  .opcode             (opcode),
  .operand1           (operand1),
  .operand2           (operand2),
  .acc                (acc),
  .pointer_select_reg (pointer_select_reg),
  .reg0_value         (reg0_value),
  .reg1_value         (reg1_value),
  .pc_next            (pc_next),
  .data_pointer       (data_pointer),
  .bank_select        (bank_select),
  .dec_valid          (dec_valid),
  .debug_break        (debug_break),
  .direct_is_sfr      (direct_is_sfr),
  .bank_reg_used      (bank_reg_used),
  .rot_carry          (rot_carry),
  .instr_class        (instr_class),
  .bank_reg_addr      (bank_reg_addr),
  .instr_bytes        (instr_bytes),
  .instr_cycles       (instr_cycles),
  .imm8               (imm8),
  .imm16              (imm16),
  .direct_addr        (direct_addr),
  .indirect_addr      (indirect_addr),
  .rot_result         (rot_result),
  .jump_target        (jump_target),
  .code_addr          (code_addr),
  .ext_addr           (ext_addr)
);

//--- testbench.sv
// Self-checking testbench for the instruction decoder
`timescale 1ns/1ns
`include "cpu_decoder_consts.vh"
module testbench;
  reg          clock, rst_n, instr_valid, carry_in;
  reg  [7:0]   opcode, operand1, operand2, acc, pointer_select_reg;
  reg  [7:0]   reg0_value, reg1_value;
  reg  [15:0]  pc_next, data_pointer;
  reg  [1:0]   bank_select;
  wire         dec_valid, debug_break;
  wire [4:0]   instr_class;
  wire [1:0]   instr_bytes;
  wire [2:0]   instr_cycles;
  wire [15:0]  jump_target;
  integer      seed, miscompares, n_tests, i, k;
  logic [27:0] notes[$];
  logic [27:0] note;
  logic [17:0] tbl[20];
  logic [63:0] r;
  logic [15:0] jt;

  cpu_instruction_decoder u_cpu_instruction_decoder (.clock, .rst_n,
    .instr_valid, .opcode, .operand1, .operand2, .pc_next, .acc, .carry_in,
    .data_pointer, .pointer_select_reg, .reg0_value, .reg1_value,
    .bank_select, .dec_valid, .instr_class, .instr_bytes, .instr_cycles,
    .imm8(), .imm16(), .indirect_addr(), .bank_reg_addr(), .bank_reg_used(),
    .direct_addr(), .direct_is_sfr(), .jump_target, .code_addr(),
    .ext_addr(), .debug_break, .rot_result(), .rot_carry());

  // Free-running core clock
  initial
  begin
    clock = 0;
    forever #10 clock = ~clock;
  end

  task check(input string what, input logic [15:0] seen, exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Drive one instruction with random state and note its expected decode
  task issue(input logic [17:0] e, input logic chk);
    @(negedge clock);
    r = {$random(seed), $random(seed)};
    {operand1, operand2, acc, pc_next, data_pointer, reg0_value} = r;
    r = $random(seed);
    {reg1_value, pointer_select_reg[7:1], carry_in, bank_select} = r[17:0];
    pointer_select_reg[0] = (e[9:5] == `CLASS_SW_BREAK);
    opcode = e[17:10];
    instr_valid = 1'b1;
    if (opcode == 8'h80)
      jt = pc_next + {{8{operand1[7]}}, operand1};
    else if (opcode[3:0] == 4'h1)
      jt = {pc_next[15:11], opcode[7:5], operand1};
    else
      jt = pc_next;
    notes.push_back({chk, e[9:0], pointer_select_reg[0], jt});
  endtask

  // Idle cycle: inputs move but no decode may come out
  task idle;
    @(negedge clock);
    instr_valid = 1'b0;
    r = $random(seed);
    opcode = r[7:0];
  endtask

  // Monitor takes the oldest note whenever a decode appears
  always @(negedge clock)
    if (rst_n && dec_valid === 1'b1)
    begin
      if (notes.size() == 0)
        check("spurious", 16'h1, 16'h0);
      else
      begin
        note = notes.pop_front();
        if (note[27])
        begin
          check("class", instr_class, note[26:22]);
          check("bytes", instr_bytes, note[21:20]);
          check("cycles", instr_cycles, note[19:17]);
          check("break", debug_break, note[16]);
          check("target", jump_target, note[15:0]);
        end
      end
    end

  // Main sequence
  initial
  begin
    seed = 32'h43800bc6;
    miscompares = 0;
    n_tests = 0;
    rst_n = 0;
    instr_valid = 0;
    {opcode, operand1, operand2, acc, pointer_select_reg} = '0;
    {reg0_value, reg1_value, pc_next, data_pointer, bank_select} = '0;
    carry_in = 0;
    tbl = '{{8'hA5, `CLASS_SW_BREAK, 5'h09}, {8'hA5, `CLASS_CODE_WR, 5'h0A},
      {8'hE0, `CLASS_EXT_MOVE, 5'h0A}, {8'hF3, `CLASS_EXT_MOVE, 5'h0A},
      {8'h93, `CLASS_CODE_DATA_POINTER, 5'h0A}, {8'h83, `CLASS_CODE_PC, 5'h0A},
      {8'h85, `CLASS_MOV_DD, 5'h1A}, {8'hD6, `CLASS_NIB_XCH, 5'h09},
      {8'hC0, `CLASS_PUSH_POP, 5'h12}, {8'hD0, `CLASS_PUSH_POP, 5'h12},
      {8'h33, `CLASS_ROT_CARRY, 5'h09}, {8'h13, `CLASS_ROT_CARRY, 5'h09},
      {8'h94, `CLASS_SUB_BORROW, 5'h11}, {8'h63, `CLASS_XOR_DIRIMM, 5'h1A},
      {8'hA0, `CLASS_OR_NBIT, 5'h12}, {8'h80, `CLASS_SHORT_JUMP, 5'h12},
      {8'h90, `CLASS_LOAD_DATA_POINTER, 5'h1A}, {8'h87, `CLASS_MOV_DIND, 5'h12},
      {8'h01, `CLASS_ABS11, 5'h12}, {8'hF1, `CLASS_ABS11, 5'h12}};
    repeat (4) @(negedge clock);
    rst_n = 1;
    // Back to back, then with gaps, then back to back again
    for (k = 0; k < 3; k = k + 1)
      for (i = 0; i < 20; i = i + 1)
      begin
        issue(tbl[i], 1'b1);
        if (k == 1)
          idle;
      end
    // Every map position must produce a decode
    for (i = 0; i < 256; i = i + 1)
      issue({i[7:0], 10'h0}, 1'b0);
    idle;
    for (i = 0; i < 10 && notes.size() > 0; i = i + 1)
      @(negedge clock);
    check("pending", notes.size(), 16'h0);
    conclude;
  end
endmodule
